// ==== rtl/iod_pkg.sv ====
// Package with the address map, field masks, reset value and request kinds of the I/O register decoder.
package iod_pkg;

    // ****************************************
    // Address spaces
    // ****************************************
    localparam logic [7:0] IOD_IO_TOP = 8'h3F;
    localparam logic [7:0] IOD_BIT_TOP = 8'h1F;
    localparam logic [7:0] IOD_DS_OFFSET = 8'h20;
    localparam logic [7:0] IOD_DS_TOP = 8'h5F;
    localparam logic [7:0] IOD_EXT_LO = 8'h60;
    localparam int IOD_LOCATIONS = 64;

    // ****************************************
    // Register offsets (I/O addresses)
    // ****************************************
    localparam logic [5:0] ADDR_PORT_B_INPUT_PINS = 6'h03;
    localparam logic [5:0] ADDR_PORT_B_DIRECTION = 6'h04;
    localparam logic [5:0] ADDR_PORT_B_OUTPUT = 6'h05;
    localparam logic [5:0] ADDR_PORT_C_INPUT_PINS = 6'h06;
    localparam logic [5:0] ADDR_PORT_C_DIRECTION = 6'h07;
    localparam logic [5:0] ADDR_PORT_C_OUTPUT = 6'h08;
    localparam logic [5:0] ADDR_PORT_D_INPUT_PINS = 6'h09;
    localparam logic [5:0] ADDR_PORT_D_DIRECTION = 6'h0A;
    localparam logic [5:0] ADDR_PORT_D_OUTPUT = 6'h0B;
    localparam logic [5:0] ADDR_TIMER0_FLAGS = 6'h15;
    localparam logic [5:0] ADDR_TIMER1_FLAGS = 6'h16;
    localparam logic [5:0] ADDR_TIMER2_FLAGS = 6'h17;
    localparam logic [5:0] ADDR_PIN_CHANGE_FLAGS = 6'h1B;
    localparam logic [5:0] ADDR_EXTERNAL_IRQ_FLAGS = 6'h1C;
    localparam logic [5:0] ADDR_EXTERNAL_IRQ_MASK = 6'h1D;
    localparam logic [5:0] ADDR_GENERAL_SCRATCH_0 = 6'h1E;
    localparam logic [5:0] ADDR_NVDATA_CONTROL = 6'h1F;
    localparam logic [5:0] ADDR_NVDATA_DATA = 6'h20;
    localparam logic [5:0] ADDR_NVDATA_ADDRESS_LOW = 6'h21;
    localparam logic [5:0] ADDR_NVDATA_ADDRESS_HIGH = 6'h22;
    localparam logic [5:0] ADDR_GENERAL_TIMER_CONTROL = 6'h23;
    localparam logic [5:0] ADDR_TIMER0_CONTROL_A = 6'h24;
    localparam logic [5:0] ADDR_TIMER0_CONTROL_B = 6'h25;
    localparam logic [5:0] ADDR_TIMER0_COUNT = 6'h26;
    localparam logic [5:0] ADDR_TIMER0_COMPARE_A = 6'h27;
    localparam logic [5:0] ADDR_TIMER0_COMPARE_B = 6'h28;
    localparam logic [5:0] ADDR_GENERAL_SCRATCH_1 = 6'h2A;
    localparam logic [5:0] ADDR_GENERAL_SCRATCH_2 = 6'h2B;
    localparam logic [5:0] ADDR_SERIAL_PORT_CONTROL = 6'h2C;
    localparam logic [5:0] ADDR_SERIAL_PORT_STATUS = 6'h2D;
    localparam logic [5:0] ADDR_SERIAL_PORT_DATA = 6'h2E;
    localparam logic [5:0] ADDR_COMPARATOR_CONTROL_STATUS = 6'h30;
    localparam logic [5:0] ADDR_SLEEP_MODE_CONTROL = 6'h33;
    localparam logic [5:0] ADDR_RESET_CAUSE_STATUS = 6'h34;
    localparam logic [5:0] ADDR_CORE_CONTROL = 6'h35;
    localparam logic [5:0] ADDR_SELF_PROGRAM_CONTROL = 6'h37;

    // ****************************************
    // Field masks and reset value
    // ****************************************
    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_PORT_C = 8'h7F;
    localparam logic [7:0] MASK_TIMER_FLAGS = 8'h07;
    localparam logic [7:0] MASK_TIMER1_FLAGS = 8'h27;
    localparam logic [7:0] MASK_PIN_CHANGE_FLAGS = 8'h07;
    localparam logic [7:0] MASK_EXT_IRQ = 8'h03;
    localparam logic [7:0] MASK_NVDATA_CONTROL = 8'h3F;
    localparam logic [7:0] MASK_GENERAL_TIMER_CONTROL = 8'h83;
    localparam logic [7:0] MASK_TIMER0_CONTROL_A = 8'hF3;
    localparam logic [7:0] MASK_TIMER0_CONTROL_B = 8'hCF;
    localparam logic [7:0] MASK_SERIAL_STATUS_WR = 8'h01;
    localparam logic [7:0] MASK_COMPARATOR_WR = 8'hCF;
    localparam logic [7:0] MASK_COMPARATOR_W1C = 8'h10;
    localparam logic [7:0] MASK_LOW_NIBBLE = 8'h0F;
    localparam logic [7:0] MASK_CORE_CONTROL = 8'h13;
    localparam logic [7:0] IOD_RESET_VAL = 8'h00;
    localparam logic [7:0] IOD_BIT_ONE = 8'h01;

    // ****************************************
    // Request kinds
    // ****************************************
    typedef enum logic [2:0] {
        IOD_IO_READ = 3'b000,
        IOD_IO_WRITE = 3'b001,
        IOD_BIT_SET = 3'b010,
        IOD_BIT_CLR = 3'b011,
        IOD_BIT_TEST = 3'b100,
        IOD_DS_READ = 3'b101,
        IOD_DS_WRITE = 3'b110,
        IOD_NOP = 3'b111
    } iod_kind_e;

endpackage

// ==== rtl/iod_decoder.sv ====
// I/O register space decoder: 64 locations, single-bit access, data-space alias and flag handling.
module iod_decoder
    import iod_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Request from the processor core
    input wire logic req_valid,
    input wire iod_kind_e req_kind,
    input wire logic [7:0] req_addr,
    input wire logic [2:0] req_bit,
    input wire logic [7:0] req_wdata,
    // Answer to the processor core
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic rsp_bit,
    output logic rsp_refused,
    output logic rsp_ext_sel,
    // Port pins
    input wire logic [7:0] pin_b_in,
    input wire logic [6:0] pin_c_in,
    input wire logic [7:0] pin_d_in,
    // Port controls
    output logic [7:0] port_b_output,
    output logic [7:0] port_b_direction,
    output logic [6:0] port_c_output,
    output logic [6:0] port_c_direction,
    output logic [7:0] port_d_output,
    output logic [7:0] port_d_direction,
    // Peripheral flag events, one-cycle pulses
    input wire logic [7:0] evt_timer0,
    input wire logic [7:0] evt_timer1,
    input wire logic [7:0] evt_timer2,
    input wire logic [7:0] evt_pin_change,
    input wire logic [7:0] evt_ext_irq,
    input wire logic evt_comparator,
    // Interrupt enables for the external lines
    output logic [1:0] external_irq_mask
);

    // ****************************************
    // Address decode functions
    // ****************************************

    // Bits that an ordinary write stores. Reserved locations and bits give zero.
    function automatic logic [7:0] wr_mask(input logic [5:0] a);
        logic [7:0] m;
        m = MASK_NONE;
        if (a == ADDR_PORT_B_DIRECTION || a == ADDR_PORT_B_OUTPUT) begin
            m = MASK_FULL;
        end else if (a == ADDR_PORT_C_DIRECTION || a == ADDR_PORT_C_OUTPUT) begin
            m = MASK_PORT_C;
        end else if (a == ADDR_PORT_D_DIRECTION || a == ADDR_PORT_D_OUTPUT) begin
            m = MASK_FULL;
        end else if (a == ADDR_EXTERNAL_IRQ_MASK) begin
            m = MASK_EXT_IRQ;
        end else if (a == ADDR_NVDATA_CONTROL) begin
            m = MASK_NVDATA_CONTROL;
        end else if (a == ADDR_GENERAL_TIMER_CONTROL) begin
            m = MASK_GENERAL_TIMER_CONTROL;
        end else if (a == ADDR_TIMER0_CONTROL_A) begin
            m = MASK_TIMER0_CONTROL_A;
        end else if (a == ADDR_TIMER0_CONTROL_B) begin
            m = MASK_TIMER0_CONTROL_B;
        end else if (a == ADDR_SERIAL_PORT_STATUS) begin
            m = MASK_SERIAL_STATUS_WR;
        end else if (a == ADDR_COMPARATOR_CONTROL_STATUS) begin
            m = MASK_COMPARATOR_WR;
        end else if (a == ADDR_SLEEP_MODE_CONTROL || a == ADDR_RESET_CAUSE_STATUS) begin
            m = MASK_LOW_NIBBLE;
        end else if (a == ADDR_CORE_CONTROL) begin
            m = MASK_CORE_CONTROL;
        end else if (a == ADDR_GENERAL_SCRATCH_0 || a == ADDR_NVDATA_DATA
                     || a == ADDR_NVDATA_ADDRESS_LOW || a == ADDR_NVDATA_ADDRESS_HIGH
                     || a == ADDR_TIMER0_COUNT || a == ADDR_TIMER0_COMPARE_A
                     || a == ADDR_TIMER0_COMPARE_B || a == ADDR_GENERAL_SCRATCH_1
                     || a == ADDR_GENERAL_SCRATCH_2 || a == ADDR_SERIAL_PORT_CONTROL
                     || a == ADDR_SERIAL_PORT_DATA || a == ADDR_SELF_PROGRAM_CONTROL) begin
            m = MASK_FULL;
        end
        return m;
    endfunction

    // Flag bits that hardware sets and a written one clears.
    function automatic logic [7:0] w1c_mask(input logic [5:0] a);
        logic [7:0] m;
        m = MASK_NONE;
        if (a == ADDR_TIMER0_FLAGS || a == ADDR_TIMER2_FLAGS) begin
            m = MASK_TIMER_FLAGS;
        end else if (a == ADDR_TIMER1_FLAGS) begin
            m = MASK_TIMER1_FLAGS;
        end else if (a == ADDR_PIN_CHANGE_FLAGS) begin
            m = MASK_PIN_CHANGE_FLAGS;
        end else if (a == ADDR_EXTERNAL_IRQ_FLAGS) begin
            m = MASK_EXT_IRQ;
        end else if (a == ADDR_COMPARATOR_CONTROL_STATUS) begin
            m = MASK_COMPARATOR_W1C;
        end
        return m;
    endfunction

    // ****************************************
    // Pin input synchronisers
    // ****************************************
    // Pins change asynchronously, so each passes three flops and the
    // visible value moves only once the second and third stage agree.
    logic [22:0] pin_raw;
    logic [22:0] pin_s1_reg;
    logic [22:0] pin_s2_reg;
    logic [22:0] pin_s3_reg;
    logic [22:0] pin_stable_reg;
    logic [22:0] pin_stable_next;
    logic [22:0] pin_agree;

    assign pin_raw = {pin_d_in, pin_c_in, pin_b_in};
    assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
    assign pin_stable_next = (pin_s3_reg & pin_agree) | (pin_stable_reg & ~pin_agree);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
            pin_stable_reg <= '0;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_stable_reg <= pin_stable_next;
        end
    end

    // ****************************************
    // Request decode
    // ****************************************
    logic kind_io;
    logic kind_bit_op;
    logic kind_ds;
    logic kind_write;
    logic io_in_range;
    logic bit_in_range;
    logic ds_in_range;
    logic ext_hit;
    logic accept;
    logic [5:0] loc;
    logic bit_wr;
    logic byte_wr;
    logic [7:0] sel_bits;
    logic [7:0] wr_val;

    assign kind_bit_op = (req_kind == IOD_BIT_SET) || (req_kind == IOD_BIT_CLR)
                         || (req_kind == IOD_BIT_TEST);
    assign kind_io = (req_kind == IOD_IO_READ) || (req_kind == IOD_IO_WRITE) || kind_bit_op;
    assign kind_ds = (req_kind == IOD_DS_READ) || (req_kind == IOD_DS_WRITE);
    assign kind_write = (req_kind == IOD_IO_WRITE) || (req_kind == IOD_DS_WRITE);
    assign io_in_range = req_addr <= IOD_IO_TOP;
    assign bit_in_range = req_addr <= IOD_BIT_TOP;
    assign ds_in_range = (req_addr >= IOD_DS_OFFSET) && (req_addr <= IOD_DS_TOP);
    assign ext_hit = req_valid && kind_ds && (req_addr >= IOD_EXT_LO);
    assign accept = req_valid && (kind_bit_op ? bit_in_range : ((kind_io && io_in_range)
                                                             || (kind_ds && ds_in_range)));
    assign loc = kind_ds ? 6'(req_addr - IOD_DS_OFFSET) : req_addr[5:0];
    assign bit_wr = accept && ((req_kind == IOD_BIT_SET) || (req_kind == IOD_BIT_CLR));
    assign byte_wr = accept && kind_write;
    assign sel_bits = bit_wr ? 8'(IOD_BIT_ONE << req_bit) : MASK_FULL;
    assign wr_val = bit_wr ? ((req_kind == IOD_BIT_SET) ? MASK_FULL : MASK_NONE) : req_wdata;

    // Hardware flag events routed to their location.
    function automatic logic [7:0] evt_for(input logic [5:0] a, input logic [7:0] t0, input logic [7:0] t1,
                                           input logic [7:0] t2, input logic [7:0] pc, input logic [7:0] ei,
                                           input logic ac);
        logic [7:0] e;
        e = MASK_NONE;
        if (a == ADDR_TIMER0_FLAGS) begin
            e = t0;
        end else if (a == ADDR_TIMER1_FLAGS) begin
            e = t1;
        end else if (a == ADDR_TIMER2_FLAGS) begin
            e = t2;
        end else if (a == ADDR_PIN_CHANGE_FLAGS) begin
            e = pc;
        end else if (a == ADDR_EXTERNAL_IRQ_FLAGS) begin
            e = ei;
        end else if (a == ADDR_COMPARATOR_CONTROL_STATUS) begin
            e = {3'b000, ac, 4'b0000};
        end
        return e & w1c_mask(a);
    endfunction

    // ****************************************
    // Register storage
    // ****************************************
    // One byte per location; the mask functions keep reserved ones at zero,
    // so synthesis trims the unused flops away.
    logic [7:0] io_mem [IOD_LOCATIONS];

    for (genvar i = 0; i < IOD_LOCATIONS; i++) begin : g_loc
        logic hit;
        logic [7:0] wm;
        logic [7:0] cm;
        logic [7:0] mem_next;

        assign hit = (bit_wr || byte_wr) && (loc == 6'(i));
        assign wm = hit ? (wr_mask(6'(i)) & sel_bits) : MASK_NONE;
        assign cm = hit ? (w1c_mask(6'(i)) & sel_bits & wr_val) : MASK_NONE;
        // A flag event in the clearing cycle wins over the clear.
        assign mem_next = (((io_mem[i] & ~wm) | (wr_val & wm)) & ~cm)
                          | evt_for(6'(i), evt_timer0, evt_timer1, evt_timer2, evt_pin_change,
                                    evt_ext_irq, evt_comparator);

        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                io_mem[i] <= IOD_RESET_VAL;
            end else begin
                io_mem[i] <= mem_next;
            end
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [7:0] pins_at_loc;
    logic [7:0] rd_val;
    logic rd_kind;
    logic rsp_valid_reg;
    logic [7:0] rsp_rdata_reg;
    logic rsp_bit_reg;
    logic rsp_refused_reg;
    logic rsp_ext_sel_reg;
    logic [7:0] rsp_rdata_next;
    logic rsp_bit_next;

    assign pins_at_loc = (loc == ADDR_PORT_B_INPUT_PINS) ? pin_stable_reg[7:0]
                       : (loc == ADDR_PORT_C_INPUT_PINS) ? {1'b0, pin_stable_reg[14:8]}
                       : (loc == ADDR_PORT_D_INPUT_PINS) ? pin_stable_reg[22:15]
                       : MASK_NONE;
    assign rd_val = pins_at_loc | (io_mem[loc] & (wr_mask(loc) | w1c_mask(loc)));
    assign rd_kind = accept && !kind_write && !bit_wr;
    assign rsp_rdata_next = rd_kind ? rd_val : MASK_NONE;
    assign rsp_bit_next = accept && (req_kind == IOD_BIT_TEST) && rd_val[req_bit];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= IOD_RESET_VAL;
            rsp_bit_reg <= 1'b0;
            rsp_refused_reg <= 1'b0;
            rsp_ext_sel_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= req_valid && (req_kind != IOD_NOP);
            rsp_rdata_reg <= rsp_rdata_next;
            rsp_bit_reg <= rsp_bit_next;
            rsp_refused_reg <= req_valid && (req_kind != IOD_NOP) && !accept && !ext_hit;
            rsp_ext_sel_reg <= ext_hit;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rsp_rdata_reg;
    assign rsp_bit = rsp_bit_reg;
    assign rsp_refused = rsp_refused_reg;
    assign rsp_ext_sel = rsp_ext_sel_reg;
    assign port_b_output = io_mem[ADDR_PORT_B_OUTPUT];
    assign port_b_direction = io_mem[ADDR_PORT_B_DIRECTION];
    assign port_c_output = io_mem[ADDR_PORT_C_OUTPUT][6:0];
    assign port_c_direction = io_mem[ADDR_PORT_C_DIRECTION][6:0];
    assign port_d_output = io_mem[ADDR_PORT_D_OUTPUT];
    assign port_d_direction = io_mem[ADDR_PORT_D_DIRECTION];
    assign external_irq_mask = io_mem[ADDR_EXTERNAL_IRQ_MASK][1:0];

endmodule

// ==== dv/iod_props.sv ====
// Checker that watches the I/O register decoder ports.
module iod_props
    import iod_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Request
    input wire logic req_valid,
    input wire iod_kind_e req_kind,
    input wire logic [7:0] req_addr,
    input wire logic [2:0] req_bit,
    input wire logic [7:0] req_wdata,
    // Answer
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_rdata,
    input wire logic rsp_bit,
    input wire logic rsp_refused,
    input wire logic rsp_ext_sel,
    // Port registers
    input wire logic [7:0] port_b_output,
    input wire logic [7:0] port_d_output
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // ****************************************
    // Request decode
    // ****************************************
    wire logic take = req_valid && (req_kind != IOD_NOP);
    wire logic bit_kind = req_kind inside {IOD_BIT_SET, IOD_BIT_CLR, IOD_BIT_TEST};
    wire logic io_kind = req_kind inside {IOD_IO_READ, IOD_IO_WRITE};
    wire logic ds_kind = req_kind inside {IOD_DS_READ, IOD_DS_WRITE};
    wire logic io_over = req_addr > IOD_IO_TOP;
    wire logic sel_d_bit = port_d_output[req_bit];
    wire logic wr_port_b = (req_kind == IOD_IO_WRITE && req_addr == 8'h05) ||
        (req_kind == IOD_DS_WRITE && req_addr == 8'h25);

    // ****************************************
    // Assertions
    // ****************************************
    answer_timing_a: assert property (take |=> rsp_valid)
        else $error("no answer one cycle after a request");
    answer_idle_a: assert property (!take |=> !rsp_valid && !rsp_refused && !rsp_ext_sel)
        else $error("answer without a request");
    bit_range_a: assert property (take && bit_kind && req_addr > IOD_BIT_TOP |=> rsp_refused && !rsp_bit)
        else $error("bit operation above the bit range not refused");
    io_window_a: assert property (take && io_kind |=> rsp_refused == $past(io_over))
        else $error("I/O window limit wrong");
    ds_extended_a: assert property (take && ds_kind && req_addr >= IOD_EXT_LO |=> rsp_ext_sel && !rsp_refused)
        else $error("extended data address not handed on");
    ds_alias_a: assert property (take && ds_kind && req_addr < IOD_DS_OFFSET |=> rsp_refused)
        else $error("data address below the alias not refused");
    port_b_write_a: assert property (take && wr_port_b |=> port_b_output == $past(req_wdata))
        else $error("port B output write lost");
    bit_set_b_a: assert property (take && req_kind == IOD_BIT_SET && req_addr == 8'h05 |=>
        port_b_output == ($past(port_b_output) | (8'h01 << $past(req_bit))))
        else $error("bit set changed other bits");
    bit_clr_b_a: assert property (take && req_kind == IOD_BIT_CLR && req_addr == 8'h05 |=>
        port_b_output == ($past(port_b_output) & ~(8'h01 << $past(req_bit))))
        else $error("bit clear changed other bits");
    bit_test_d_a: assert property (take && req_kind == IOD_BIT_TEST && req_addr == 8'h0B |=>
        rsp_bit == $past(sel_d_bit))
        else $error("bit test gave the wrong bit");
    port_c_top_a: assert property (take && req_kind == IOD_IO_READ &&
        req_addr inside {8'h06, 8'h07, 8'h08} |=> rsp_rdata[7] == 1'b0)
        else $error("port C top bit read as one");

    cover_bit_set_c: cover property (take && req_kind == IOD_BIT_SET ##1 rsp_valid);
    cover_ext_c: cover property (take && ds_kind ##1 rsp_ext_sel);
    cover_refused_c: cover property (take && bit_kind ##1 rsp_refused);
endmodule

bind iod_decoder iod_props iod_props_inst (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid),
    .req_kind(req_kind), .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_bit(rsp_bit), .rsp_refused(rsp_refused),
    .rsp_ext_sel(rsp_ext_sel), .port_b_output(port_b_output), .port_d_output(port_d_output));

// ==== dv/iod_core_model.sv ====
// Processor core model that issues one register request at a time.
module iod_core_model
    import iod_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Request to the decoder
    output logic req_valid,
    output iod_kind_e req_kind,
    output logic [7:0] req_addr,
    output logic [2:0] req_bit,
    output logic [7:0] req_wdata,
    // Answer from the decoder
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_rdata,
    input wire logic rsp_bit,
    input wire logic rsp_refused,
    input wire logic rsp_ext_sel
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        req_valid = 1'b0;
        req_kind = IOD_NOP;
        req_addr = 8'h00;
        req_bit = 3'h0;
        req_wdata = 8'h00;
    end

    // Callers pass only mapped locations for writes, never reserved ones.
    task automatic access(input iod_kind_e kind, input logic [7:0] addr, input logic [2:0] bi,
        input logic [7:0] wd, output logic [7:0] rd, output logic rb, output logic [1:0] fl, output logic ok);
        @(posedge mclk);
        while (!arst_n) @(posedge mclk);
        #1;
        req_valid = 1'b1;
        req_kind = kind;
        req_addr = addr;
        req_bit = bi;
        req_wdata = wd;
        @(posedge mclk);
        #1;
        ok = rsp_valid;
        rd = rsp_rdata;
        rb = rsp_bit;
        fl = {rsp_ext_sel, rsp_refused};
        // Released address, bit and data lines are inverted so a stale value can never pass for a good one.
        req_valid = 1'b0;
        req_kind = IOD_NOP;
        req_addr = ~addr;
        req_bit = ~bi;
        req_wdata = ~wd;
    endtask
endmodule

// ==== dv/io_register_space_decode_test.sv ====
// Self-checking testbench for the I/O register decoder.
module io_register_space_decode_test;
    import iod_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid, rsp_valid, rsp_bit, rsp_refused, rsp_ext_sel, evt_comparator, rb, ok;
    iod_kind_e req_kind;
    logic [7:0] req_addr, req_wdata, rsp_rdata, pin_b_in, pin_d_in, port_b_output, port_b_direction;
    logic [7:0] port_d_output, port_d_direction, evt_timer0, evt_timer1, evt_timer2, evt_pin_change;
    logic [7:0] evt_ext_irq, rd;
    logic [6:0] pin_c_in, port_c_output, port_c_direction;
    logic [2:0] req_bit;
    logic [1:0] external_irq_mask, fl;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] t_addr [19] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h1D, 8'h1E, 8'h1F, 8'h23,
        8'h24, 8'h25, 8'h2E, 8'h33, 8'h35, 8'h0C, 8'h29, 8'h2F, 8'h3C};
    logic [7:0] t_mask [19] = '{8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'h3F, 8'h83,
        8'hF3, 8'hCF, 8'hFF, 8'h0F, 8'h13, 8'h00, 8'h00, 8'h00, 8'h00};

    always #50 mclk = ~mclk;

    iod_decoder iod_decoder_inst (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid), .req_kind(req_kind),
        .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_bit(rsp_bit), .rsp_refused(rsp_refused), .rsp_ext_sel(rsp_ext_sel),
        .pin_b_in(pin_b_in), .pin_c_in(pin_c_in), .pin_d_in(pin_d_in), .port_b_output(port_b_output),
        .port_b_direction(port_b_direction), .port_c_output(port_c_output),
        .port_c_direction(port_c_direction), .port_d_output(port_d_output),
        .port_d_direction(port_d_direction), .evt_timer0(evt_timer0), .evt_timer1(evt_timer1),
        .evt_timer2(evt_timer2), .evt_pin_change(evt_pin_change), .evt_ext_irq(evt_ext_irq),
        .evt_comparator(evt_comparator), .external_irq_mask(external_irq_mask));

    iod_core_model iod_core_model_inst (.mclk(mclk), .arst_n(arst_n), .req_valid(req_valid),
        .req_kind(req_kind), .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_bit(rsp_bit), .rsp_refused(rsp_refused),
        .rsp_ext_sel(rsp_ext_sel));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic io(input iod_kind_e kind, input logic [7:0] addr, input logic [2:0] bi, input logic [7:0] wd);
        iod_core_model_inst.access(kind, addr, bi, wd, rd, rb, fl, ok);
        check("answer valid", 8'h01, {7'h00, ok});
    endtask

    task automatic rd_chk(input iod_kind_e kind, input logic [7:0] addr, input logic [7:0] exp);
        io(kind, addr, 3'h0, 8'h00);
        check("read data", exp, rd);
    endtask

    task automatic flag_chk(input iod_kind_e kind, input logic [7:0] addr, input logic [1:0] exp);
        io(kind, addr, 3'h0, 8'h55);
        check("ext and refused", {6'h00, exp}, {6'h00, fl});
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {pin_b_in, pin_c_in, pin_d_in} = '0;
        {evt_timer0, evt_timer1, evt_timer2, evt_pin_change, evt_ext_irq, evt_comparator} = '0;
        repeat (10) @(posedge mclk);
        #1 arst_n = 1'b1;
        foreach (t_addr[i]) rd_chk(IOD_IO_READ, t_addr[i], 8'h00);
        foreach (t_addr[i]) if (t_mask[i] != 8'h00) io(IOD_IO_WRITE, t_addr[i], 3'h0, 8'hFF);
        foreach (t_addr[i]) rd_chk(IOD_DS_READ, t_addr[i] + IOD_DS_OFFSET, t_mask[i]);
        check("port b output", 8'hFF, port_b_output);
        check("port c direction", 8'h7F, {1'b0, port_c_direction});
        check("port d direction", 8'hFF, port_d_direction);
        check("port b direction", 8'hFF, port_b_direction);
        check("port c output", 8'h7F, {1'b0, port_c_output});
        check("port d output", 8'hFF, port_d_output);
        check("irq mask", 8'h03, {6'h00, external_irq_mask});
        io(IOD_BIT_CLR, 8'h05, 3'h3, 8'h00);
        check("bit clear", 8'hF7, port_b_output);
        io(IOD_BIT_TEST, 8'h05, 3'h3, 8'h00);
        check("bit test clear", 8'h00, {7'h00, rb});
        io(IOD_BIT_SET, 8'h05, 3'h3, 8'h00);
        check("bit set", 8'hFF, port_b_output);
        io(IOD_BIT_TEST, 8'h0B, 3'h7, 8'h00);
        check("bit test set", 8'h01, {7'h00, rb});
        io(IOD_DS_WRITE, 8'h25, 3'h0, 8'hA5);
        check("alias write", 8'hA5, port_b_output);
        flag_chk(IOD_BIT_SET, 8'h20, 2'b01);
        flag_chk(IOD_BIT_TEST, 8'h1F, 2'b00);
        flag_chk(IOD_IO_READ, 8'h40, 2'b01);
        flag_chk(IOD_IO_READ, 8'h3F, 2'b00);
        flag_chk(IOD_DS_READ, 8'h1F, 2'b01);
        flag_chk(IOD_DS_WRITE, 8'h60, 2'b10);
        flag_chk(IOD_DS_READ, 8'hFF, 2'b10);
        @(posedge mclk);
        #1 pin_b_in = 8'h5A;
        pin_c_in = 7'h33;
        pin_d_in = 8'hC3;
        repeat (6) @(posedge mclk);
        rd_chk(IOD_IO_READ, 8'h03, 8'h5A);
        rd_chk(IOD_IO_READ, 8'h06, 8'h33);
        rd_chk(IOD_DS_READ, 8'h29, 8'hC3);
        @(posedge mclk);
        #1 evt_ext_irq = 8'h03;
        evt_timer1 = 8'hFF;
        evt_comparator = 1'b1;
        {evt_timer0, evt_timer2, evt_pin_change} = '1;
        @(posedge mclk);
        #1 {evt_timer0, evt_timer1, evt_timer2, evt_pin_change, evt_ext_irq, evt_comparator} = '0;
        rd_chk(IOD_IO_READ, 8'h16, 8'h27);
        rd_chk(IOD_IO_READ, 8'h15, 8'h07);
        rd_chk(IOD_DS_READ, 8'h37, 8'h07);
        io(IOD_BIT_CLR, 8'h1B, 3'h1, 8'h00);
        io(IOD_IO_WRITE, 8'h1B, 3'h0, 8'h05);
        rd_chk(IOD_IO_READ, 8'h1B, 8'h02);
        rd_chk(IOD_IO_READ, 8'h30, 8'h10);
        rd_chk(IOD_IO_READ, 8'h1C, 8'h03);
        io(IOD_BIT_SET, 8'h1C, 3'h0, 8'h00);
        rd_chk(IOD_IO_READ, 8'h1C, 8'h02);
        io(IOD_IO_WRITE, 8'h1C, 3'h0, 8'h00);
        rd_chk(IOD_IO_READ, 8'h1C, 8'h02);
        io(IOD_IO_WRITE, 8'h1C, 3'h0, 8'h02);
        rd_chk(IOD_IO_READ, 8'h1C, 8'h00);
        io(IOD_IO_WRITE, 8'h16, 3'h0, 8'h20);
        rd_chk(IOD_IO_READ, 8'h16, 8'h07);
        report_and_stop();
    end
endmodule
